// ---- hdl/rtg_timing_gen.sv ----
// Raster read timing generator: pixel rate, raster counters, sync, blanking and memory read control.
`timescale 1ns/1ns
module rtg_timing_gen
   import rtg_pkg::*;
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              srst,
   // Board straps, read sizes and parameter buffer status
   input  wire logic              adapter_fitted,
   input  wire logic [WORD_W-1:0] words_ch0,
   input  wire logic [WORD_W-1:0] words_ch1,
   input  wire logic [WORD_W-1:0] words_ch2,
   input  wire logic              param_fifo_nempty,
   // Non-interlaced raster timing
   output logic                   timing_pixel_clock_tap,
   output logic                   odd_even_line,
   output logic                   line_gate,
   output logic                   comp_blank,
   output logic                   comp_sync,
   output logic                   vert_drive,
   output logic                   vert_gate,
   // Interlaced path
   output logic                   ilace_sync,
   output logic                   ilace_blank,
   output logic                   ilace_store,
   output logic                   ilace_replay,
   output logic                   ch1_sync,
   output logic                   ch2_sync,
   // Display memory
   output logic                   ext_refresh,
   output logic                   raster_read_start,
   output logic                   mem_owner_host,
   output logic [N_CHAN-1:0]      chan_read_busy,
   output logic [N_CHAN-1:0]      chan_word_stb,
   // Host side
   output logic                   frame_int,
   output logic                   param_fifo_rd
);

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(PIX_FREQ_DHZ);
   localparam logic [ACC_W-1:0] ACC_MOD  = ACC_W'(CLK_FREQ_DHZ);

   logic [ACC_W-1:0]  acc_reg;
   logic [ACC_W-1:0]  acc_sum;
   logic              pix_en;
   logic [PX_W-1:0]   px_reg;
   logic [LN_W-1:0]   line_reg;
   logic              line_end;
   logic [IPX_W-1:0]  ipx;
   logic              hsync;
   logic              vsync_line;
   logic              csync_next;
   logic              isync_next;
   logic              launch;
   logic [N_CHAN-1:0] ch_start;
   logic [N_CHAN-1:0] ch_done;
   logic [WORD_W-1:0] ch_words [N_CHAN];
   logic [15:0]       line_clk_cnt_reg;

   // A phase accumulator turns the single clock into the pixel rate; the
   // period jitters between four and five clocks but the average is exact.
   assign acc_sum = acc_reg + ACC_STEP;

   always_ff @(posedge clk) begin
      if (srst) begin
         acc_reg <= 31'h00000000;
         pix_en  <= 1'b0;
      end else if (acc_sum >= ACC_MOD) begin
         acc_reg <= acc_sum - ACC_MOD;
         pix_en  <= 1'b1;
      end else begin
         acc_reg <= acc_sum;
         pix_en  <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         timing_pixel_clock_tap <= 1'b0;
      end else begin
         timing_pixel_clock_tap <= pix_en;
      end
   end

   // Raster counters.
   assign line_end = pix_en && (px_reg == H_LAST);

   always_ff @(posedge clk) begin
      if (srst) begin
         px_reg <= 10'h000;
      end else if (line_end) begin
         px_reg <= 10'h000;
      end else if (pix_en) begin
         px_reg <= px_reg + 10'h001;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         line_reg <= 10'h000;
      end else if (line_end) begin
         line_reg <= (line_reg == V_LAST) ? 10'h000 : line_reg + 10'h001;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         odd_even_line <= 1'b0;
      end else if (line_end) begin
         odd_even_line <= ~odd_even_line;
      end
   end

   // The frame holds an odd number of lines, so the toggle flips phase each
   // frame and successive frames land on opposite interlaced fields.
   always_ff @(posedge clk) begin
      if (srst) begin
         frame_int <= 1'b0;
      end else if (line_end && line_reg == V_LAST) begin
         frame_int <= ~frame_int;
      end
   end

   // Position within the two-line interlaced period.
   assign ipx = odd_even_line ? IPX_W'(px_reg) + IPX_W'(H_TOTAL) : IPX_W'(px_reg);
   assign hsync      = (px_reg >= HSYNC_START) || (px_reg < HSYNC_END);
   assign vsync_line = (line_reg >= VSYNC_FIRST) && (line_reg <= VSYNC_LAST);
   assign csync_next = vsync_line ? (px_reg < SERR_END) : hsync;
   assign isync_next = vsync_line ? (ipx < IL_SERR_END)
                                  : ((ipx >= IL_HSYNC_START) || (ipx < IL_HSYNC_END));

   // Decodes are registered on the pixel rate, one pixel behind the counters.
   always_ff @(posedge clk) begin
      if (srst) begin
         line_gate   <= 1'b0;
         comp_blank  <= 1'b1;
         comp_sync   <= 1'b0;
         vert_drive  <= 1'b0;
         vert_gate   <= 1'b0;
         ext_refresh <= 1'b0;
      end else if (pix_en) begin
         line_gate   <= (px_reg >= LGATE_FIRST) && (px_reg <= LGATE_LAST);
         comp_blank  <= (px_reg < LGATE_FIRST) || (px_reg > LGATE_LAST)
                        || (line_reg < VIS_FIRST) || (line_reg > VIS_LAST);
         comp_sync   <= csync_next;
         vert_drive  <= vsync_line;
         vert_gate   <= (line_reg <= VGATE_LAST);
         ext_refresh <= (px_reg >= REFRESH_FIRST) && (px_reg <= REFRESH_LAST);
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         ilace_sync  <= 1'b0;
         ilace_blank <= 1'b1;
         ch1_sync    <= 1'b0;
         ch2_sync    <= 1'b0;
      end else if (pix_en) begin
         ilace_sync  <= isync_next;
         ilace_blank <= (ipx >= IL_HBLANK_START) || (ipx < IL_HBLANK_END)
                        || (line_reg < VIS_FIRST) || (line_reg > VIS_LAST);
         ch1_sync    <= adapter_fitted ? isync_next : csync_next;
         ch2_sync    <= adapter_fitted ? isync_next : csync_next;
      end
   end

   // Store on even lines, replay every second pixel over the doubled period.
   always_ff @(posedge clk) begin
      if (srst) begin
         ilace_store  <= 1'b0;
         ilace_replay <= 1'b0;
      end else begin
         ilace_store  <= pix_en && !odd_even_line
                         && (px_reg >= LGATE_FIRST) && (px_reg <= LGATE_LAST);
         ilace_replay <= pix_en && ipx[0] && (ipx >= IL_HBLANK_END) && (ipx < IL_HBLANK_START);
      end
   end

   // Inbound parameters drain only inside the vertical gate so no visible line is touched.
   always_ff @(posedge clk) begin
      if (srst) begin
         param_fifo_rd <= 1'b0;
      end else begin
         param_fifo_rd <= pix_en && (line_reg <= VGATE_LAST) && param_fifo_nempty;
      end
   end

   // Raster read start and the three chained read cycles.
   assign launch = pix_en && (px_reg == READ_START_PX);

   always_ff @(posedge clk) begin
      if (srst) begin
         raster_read_start <= 1'b0;
      end else if (pix_en) begin
         raster_read_start <= (px_reg == READ_START_PX);
      end
   end

   assign ch_words[0] = words_ch0;
   assign ch_words[1] = words_ch1;
   assign ch_words[2] = words_ch2;

   for (genvar i = 0; i < N_CHAN; i++) begin : g_chan
      if (i == 0) begin : g_first
         assign ch_start[i] = launch;
      end else begin : g_next
         assign ch_start[i] = ch_done[i-1];
      end
      rtg_seq_read #(
         .MAX_WORDS_P (MAX_WORDS)
      ) u_read (
         .clk      (clk),
         .srst     (srst),
         .start    (ch_start[i]),
         .words    (ch_words[i]),
         .busy     (chan_read_busy[i]),
         .word_stb (chan_word_stb[i]),
         .done     (ch_done[i])
      );
   end

   // The host keeps the memory from the end of the reads through the next
   // line start, so an access it began late in a line can finish.
   always_ff @(posedge clk) begin
      if (srst) begin
         mem_owner_host <= OWNER_HOST_RST;
      end else if (launch) begin
         mem_owner_host <= 1'b0;
      end else if (ch_done[N_CHAN-1]) begin
         mem_owner_host <= 1'b1;
      end
   end

   // Helper clock count from line start, read only by the checks.
   always_ff @(posedge clk) begin
      if (srst || line_end) begin
         line_clk_cnt_reg <= 16'h0000;
      end else if (line_clk_cnt_reg != 16'hFFFF) begin
         line_clk_cnt_reg <= line_clk_cnt_reg + 16'h0001;
      end
   end

   a_pixel_spacing: assert property (pix_en |=> !pix_en [*3])
      else $error("pixel enables closer than four clocks");

   a_pixel_wrap: assert property (line_end |=> px_reg == 10'h000)
      else $error("pixel counter did not wrap after 779");

   a_pixel_step: assert property (pix_en && px_reg != H_LAST |=> px_reg == $past(px_reg) + 10'h001)
      else $error("pixel counter did not advance");

   a_line_wrap: assert property (line_end && line_reg == V_LAST |=> line_reg == 10'h000)
      else $error("line counter did not wrap after 524");

   a_odd_even: assert property (line_end |=> odd_even_line != $past(odd_even_line))
      else $error("odd/even line did not toggle at line start");

   a_line_gate: assert property (pix_en |=> line_gate ==
      ($past(px_reg) >= LGATE_FIRST && $past(px_reg) <= LGATE_LAST))
      else $error("line gate outside pixels 128 to 767");

   a_refresh_win: assert property (pix_en |=> ext_refresh ==
      ($past(px_reg) >= REFRESH_FIRST && $past(px_reg) <= REFRESH_LAST))
      else $error("refresh enable outside pixels 20 to 59");

   a_start_width: assert property ($rose(raster_read_start) |->
      raster_read_start [*4] ##[1:2] !raster_read_start)
      else $error("read start not one pixel wide");

   a_owner_fall: assert property ($rose(raster_read_start) |-> !mem_owner_host && chan_read_busy == 3'h1)
      else $error("owner select did not fall at read start");

   a_chain_next: assert property (ch_done[0] |=> chan_read_busy[1])
      else $error("second read cycle not launched by the first");

   a_owner_rise: assert property (ch_done[N_CHAN-1] |=> mem_owner_host && !(|chan_read_busy))
      else $error("owner select not high when reads finish");

   a_access_bound: assert property (|chan_read_busy |-> line_clk_cnt_reg < 16'(ACCESS_LIMIT_CLK))
      else $error("display access ran past 20.5 us");

   a_vert_drive: assert property (pix_en |=> vert_drive ==
      ($past(line_reg) >= VSYNC_FIRST && $past(line_reg) <= VSYNC_LAST))
      else $error("vertical drive outside lines 6 to 11");

   a_vert_gate: assert property (pix_en |=> vert_gate == ($past(line_reg) <= VGATE_LAST))
      else $error("vertical gate outside lines 0 to 42");

   a_serration: assert property (pix_en && vsync_line |=> comp_sync == ($past(px_reg) < SERR_END))
      else $error("serrated sync wrong on vertical sync line");

   a_frame_int: assert property (line_end && line_reg == V_LAST |=> frame_int != $past(frame_int))
      else $error("frame interrupt did not toggle at frame end");

   a_chan_sync: assert property (pix_en && adapter_fitted |=> ch1_sync == ilace_sync && ch2_sync == ilace_sync)
      else $error("channel sync not interlaced with adapter fitted");

   a_param_gate: assert property (param_fifo_rd |-> vert_gate)
      else $error("parameter read outside vertical gate");

   // Blanking must hide every pixel that the line gate leaves out.
   a_blank_horiz: assert property (!line_gate |-> comp_blank)
      else $error("composite blanking open outside the line gate");

   a_blank_vert: assert property (vert_gate |-> comp_blank)
      else $error("composite blanking open inside the vertical gate");

   c_frame_wrap: cover property (line_end && line_reg == V_LAST);
   c_read_chain: cover property (ch_done[N_CHAN-1]);
   c_word_fetch: cover property (chan_word_stb[N_CHAN-1]);
   c_adapter:    cover property (pix_en && adapter_fitted && vsync_line);

endmodule

// ---- hdl/rtg_pkg.sv ----
// Constants shared by the raster read timing generator and its sequential read engine.
package rtg_pkg;

   // Time base: clock and pixel rates in tenths of a hertz.
   localparam int CLK_FREQ_DHZ = 1000000000;
   localparam int PIX_FREQ_DHZ = 245454514;
   localparam int CLK_MHZ      = 100;
   localparam int ACC_W        = 31;

   // Raster geometry.
   localparam int PX_W  = 10;
   localparam int LN_W  = 10;
   localparam int IPX_W = 11;
   localparam logic [PX_W-1:0] H_LAST       = 10'h30B;
   localparam logic [PX_W-1:0] H_TOTAL      = 10'h30C;
   localparam logic [PX_W-1:0] LGATE_FIRST  = 10'h080;
   localparam logic [PX_W-1:0] LGATE_LAST   = 10'h2FF;
   localparam logic [PX_W-1:0] HSYNC_START  = 10'h302;
   localparam logic [PX_W-1:0] HSYNC_END    = 10'h054;
   localparam logic [PX_W-1:0] SERR_END     = 10'h2D0;
   localparam logic [PX_W-1:0] REFRESH_FIRST = 10'h014;
   localparam logic [PX_W-1:0] REFRESH_LAST  = 10'h03B;
   localparam logic [PX_W-1:0] READ_START_PX = 10'h03E;
   localparam logic [LN_W-1:0] V_LAST       = 10'h20C;
   localparam logic [LN_W-1:0] VSYNC_FIRST  = 10'h006;
   localparam logic [LN_W-1:0] VSYNC_LAST   = 10'h00B;
   localparam logic [LN_W-1:0] VGATE_LAST   = 10'h02A;
   localparam logic [LN_W-1:0] VIS_FIRST    = 10'h02C;
   localparam logic [LN_W-1:0] VIS_LAST     = 10'h20B;

   // Interlaced line spans two non-interlaced lines, 1560 pixels.
   localparam logic [IPX_W-1:0] IL_HSYNC_START  = 11'h60E;
   localparam logic [IPX_W-1:0] IL_HSYNC_END    = 11'h0A8;
   localparam logic [IPX_W-1:0] IL_HBLANK_START = 11'h600;
   localparam logic [IPX_W-1:0] IL_HBLANK_END   = 11'h100;
   localparam logic [IPX_W-1:0] IL_SERR_END     = 11'h5A0;

   // Sequential read cycle timing.
   localparam int N_CHAN    = 3;
   localparam int WORD_W    = 6;
   localparam int MAX_WORDS = 41;
   localparam int SYNC_NS   = 480;
   localparam int WORD_NS   = 120;
   localparam int END_NS    = 480;
   localparam int SYNC_CLK  = (SYNC_NS * CLK_MHZ + 999) / 1000;
   localparam int WORD_CLK  = (WORD_NS * CLK_MHZ + 999) / 1000;
   localparam int END_CLK   = (END_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W     = 8;
   localparam int ACCESS_LIMIT_NS  = 20500;
   localparam int ACCESS_LIMIT_CLK = ACCESS_LIMIT_NS * CLK_MHZ / 1000;

   // Values after reset.
   localparam logic OWNER_HOST_RST = 1'b1;

   typedef enum logic [1:0] {RTG_RD_IDLE, RTG_RD_SYNC, RTG_RD_WORDS, RTG_RD_END} rtg_rd_state_t;

endpackage

// ---- hdl/rtg_seq_read.sv ----
// One sequential read cycle: sync phase, one slot per word, ending sequence.
`timescale 1ns/1ns
module rtg_seq_read
   import rtg_pkg::*;
#(
   parameter int MAX_WORDS_P = MAX_WORDS
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              srst,
   // Launch and word count
   input  wire logic              start,
   input  wire logic [WORD_W-1:0] words,
   // Progress
   output logic                   busy,
   output logic                   word_stb,
   output logic                   done
);

   if (MAX_WORDS_P < 1 || MAX_WORDS_P > 2**WORD_W - 1) begin : g_bad_words
      $error("MAX_WORDS_P does not fit the word count port");
   end

   localparam logic [CNT_W-1:0]  SYNC_LOAD = CNT_W'(SYNC_CLK - 1);
   localparam logic [CNT_W-1:0]  WORD_LOAD = CNT_W'(WORD_CLK - 1);
   localparam logic [CNT_W-1:0]  END_LOAD  = CNT_W'(END_CLK - 1);
   localparam logic [WORD_W-1:0] WORD_CAP  = WORD_W'(MAX_WORDS_P);

   rtg_rd_state_t     state_reg;
   logic [CNT_W-1:0]  cnt_reg;
   logic [WORD_W-1:0] left_reg;
   logic [WORD_W-1:0] words_lat_reg;
   logic [15:0]       len_cnt_reg;

   // A launch while a cycle runs is ignored; the chain never overlaps.
   always_ff @(posedge clk) begin
      if (srst) begin
         state_reg     <= RTG_RD_IDLE;
         cnt_reg       <= 8'h00;
         left_reg      <= 6'h00;
         words_lat_reg <= 6'h00;
         busy          <= 1'b0;
         word_stb      <= 1'b0;
         done          <= 1'b0;
      end else begin
         word_stb <= 1'b0;
         done     <= 1'b0;
         case (state_reg)
            RTG_RD_IDLE: begin
               if (start) begin
                  state_reg     <= RTG_RD_SYNC;
                  cnt_reg       <= SYNC_LOAD;
                  left_reg      <= (words > WORD_CAP) ? WORD_CAP : words;
                  words_lat_reg <= (words > WORD_CAP) ? WORD_CAP : words;
                  busy          <= 1'b1;
               end
            end
            RTG_RD_SYNC: begin
               if (cnt_reg != 8'h00) begin
                  cnt_reg <= cnt_reg - 8'h01;
               end else if (left_reg == 6'h00) begin
                  state_reg <= RTG_RD_END;
                  cnt_reg   <= END_LOAD;
               end else begin
                  state_reg <= RTG_RD_WORDS;
                  cnt_reg   <= WORD_LOAD;
               end
            end
            RTG_RD_WORDS: begin
               if (cnt_reg != 8'h00) begin
                  cnt_reg <= cnt_reg - 8'h01;
               end else begin
                  word_stb <= 1'b1;
                  left_reg <= left_reg - 6'h01;
                  if (left_reg == 6'h01) begin
                     state_reg <= RTG_RD_END;
                     cnt_reg   <= END_LOAD;
                  end else begin
                     cnt_reg <= WORD_LOAD;
                  end
               end
            end
            RTG_RD_END: begin
               if (cnt_reg != 8'h00) begin
                  cnt_reg <= cnt_reg - 8'h01;
               end else begin
                  state_reg <= RTG_RD_IDLE;
                  busy      <= 1'b0;
                  done      <= 1'b1;
               end
            end
            default: begin
               state_reg <= RTG_RD_IDLE;
               busy      <= 1'b0;
            end
         endcase
      end
   end

   // Helper count of busy cycles, read only by the check below.
   always_ff @(posedge clk) begin
      if (srst || (start && !busy)) begin
         len_cnt_reg <= 16'h0000;
      end else if (busy) begin
         len_cnt_reg <= len_cnt_reg + 16'h0001;
      end
   end

   a_burst_length: assert property (@(posedge clk) disable iff (srst)
      done |-> len_cnt_reg == 16'(SYNC_CLK + END_CLK + WORD_CLK * int'(words_lat_reg)))
      else $error("read cycle length differs from sync, words and ending");

endmodule

// ---- testbench/rtg_host_model.sv ----
// Host-side model: inbound parameter buffer and memory access gating.
`timescale 1ns/1ns
module rtg_host_model (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       srst,
   // Bench load
   input  wire logic       fill,
   input  wire logic [7:0] fill_cnt,
   // Device handshakes
   input  wire logic       mem_owner_host,
   input  wire logic       param_fifo_rd,
   output logic            param_fifo_nempty
);
   logic [7:0] depth_reg;
   int         host_acc;

   assign param_fifo_nempty = (depth_reg != 8'h00);

   // Entries written in picture time leave only when the device pulls them.
   always_ff @(posedge clk) begin
      if (srst)
         depth_reg <= 8'h00;
      else if (fill)
         depth_reg <= fill_cnt;
      else if (param_fifo_rd && param_fifo_nempty)
         depth_reg <= depth_reg - 8'h01;
   end

   // The host only opens a memory cycle while the select grants it the memory.
   always_ff @(posedge clk) begin
      if (srst)
         host_acc <= 0;
      else if (mem_owner_host)
         host_acc <= host_acc + 1;
   end
endmodule

// ---- testbench/tb.sv ----
// Self-checking bench for the raster read timing generator.
`timescale 1ns/1ns
module tb;
   import rtg_pkg::*;
   logic              clk = 1'b0;
   logic              srst = 1'b1;
   logic              adapter_fitted = 1'b0;
   logic [WORD_W-1:0] words_ch0 = 6'h00, words_ch1 = 6'h00, words_ch2 = 6'h00;
   logic              fill = 1'b0;
   logic [7:0]        fill_cnt = 8'h05;
   logic              param_fifo_nempty, param_fifo_rd, frame_int, mem_owner_host;
   logic              timing_pixel_clock_tap, odd_even_line, line_gate, comp_blank, comp_sync;
   logic              vert_drive, vert_gate, ilace_sync, ilace_blank, ilace_store, ilace_replay;
   logic              ch1_sync, ch2_sync, ext_refresh, raster_read_start;
   logic [N_CHAN-1:0] chan_read_busy, chan_word_stb;
   int                mismatches = 0, checks_done = 0, seed = 32'h934B;
   int                cyc = 0, gap = 0, taps = 0, line_no = 0, ln_start = 0, n_rd = 0;
   int                cnt [15];
   logic              oe_prev = 1'b0;
   bit                flip = 1'b0;

   rtg_timing_gen i_rtg_timing_gen (.*);
   rtg_host_model i_rtg_host_model (.*);

   always #5 clk = ~clk;

   task automatic chk(input string what, input int exp, input int got);
      checks_done++;
      if (exp !== got) begin
         mismatches++;
         $display("[ERR] %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Sync pixels per line; an interlaced line spans an even and an odd line.
   function automatic int exp_sync(input int ln, input bit oe, input bit il);
      if (ln >= 6 && ln <= 11)
         return il ? (oe ? 660 : 780) : 720;
      return il ? (oe ? 10 : 168) : 94;
   endfunction

   function automatic logic [WORD_W-1:0] pick_words();
      if (line_no == 1)
         return 6'h29;
      if (line_no == 2)
         return 6'h3F;
      if (line_no == 3)
         return 6'h00;
      return 6'($random(seed));
   endfunction

   task automatic end_line();
      bit v;
      v = (line_no >= 6 && line_no <= 11);
      chk("pixels", 780, cnt[0]);
      chk("line_gate", 640, cnt[1]);
      chk("refresh", 40, cnt[2]);
      chk("read_start_taps", 1, cnt[3]);
      chk("read_start_len", 1, cnt[12] == 4 || cnt[12] == 5);
      chk("comp_blank", 780, cnt[4]);
      chk("comp_sync", exp_sync(line_no, oe_prev, 1'b0), cnt[5]);
      chk("ilace_sync", exp_sync(line_no, oe_prev, 1'b1), cnt[6]);
      chk("store", oe_prev ? 0 : 640, cnt[7]);
      chk("replay", oe_prev ? 378 : 262, cnt[8]);
      chk("vert_drive", v ? 780 : 0, cnt[9]);
      chk("vert_gate", 780, cnt[10]);
      chk("chan_sync", 0, cnt[11]);
      chk("frame_int", 0, cnt[13]);
      chk("ilace_blank", 780, cnt[14]);
      $display("line %0d done", line_no);
   endtask

   // Samples are booked before the line check: the tap that shows the toggle
   // still carries the decode of the last pixel of the line that ends.
   always @(negedge clk) begin
      cyc++;
      gap++;
      if (!srst) begin
         cnt[7] += (ilace_store === 1'b1);
         cnt[8] += (ilace_replay === 1'b1);
         cnt[12] += (raster_read_start === 1'b1);
         n_rd += (param_fifo_rd === 1'b1);
      end
      if (!srst && timing_pixel_clock_tap === 1'b1) begin
         if (taps > 0)
            chk("tap_gap", 1, gap == 4 || gap == 5);
         taps++;
         gap = 0;
         cnt[0]++;
         cnt[1] += (line_gate === 1'b1);
         cnt[2] += (ext_refresh === 1'b1);
         cnt[3] += (raster_read_start === 1'b1);
         cnt[4] += (comp_blank === 1'b1);
         cnt[5] += (comp_sync === 1'b1);
         cnt[6] += (ilace_sync === 1'b1);
         cnt[9] += (vert_drive === 1'b1);
         cnt[10] += (vert_gate === 1'b1);
         cnt[11] += (ch1_sync !== (adapter_fitted ? ilace_sync : comp_sync));
         cnt[11] += (ch2_sync !== (adapter_fitted ? ilace_sync : comp_sync));
         cnt[13] += (frame_int === 1'b1);
         cnt[14] += (ilace_blank === 1'b1);
         if (odd_even_line !== oe_prev) begin
            if (line_no > 0)
               end_line();
            if (line_no > 0)
               chk("owner_line_start", 1, mem_owner_host === 1'b1);
            line_no++;
            oe_prev = odd_even_line;
            cnt = '{default: 0};
            ln_start = cyc;
            flip = 1'b1;
         end
      end
   end

   // New straps and sizes land at a line start, well clear of the read launch.
   always @(posedge clk) begin
      if (flip) begin
         #1;
         flip = 1'b0;
         adapter_fitted = 1'($random(seed));
         words_ch0 = pick_words();
         words_ch1 = pick_words();
         words_ch2 = pick_words();
      end
   end

   task automatic chk_read();
      int n, c, s;
      logic [WORD_W-1:0] w [3];
      w = '{words_ch0, words_ch1, words_ch2};
      @(negedge clk);
      chk("owner_low", 0, mem_owner_host === 1'b1);
      for (int ch = 0; ch < 3; ch++) begin
         n = (w[ch] > 6'h29) ? 41 : int'(w[ch]);
         c = 0;
         s = 0;
         while (chan_read_busy[ch] === 1'b1 && c < 2000) begin
            s += (chan_word_stb[ch] === 1'b1);
            c++;
            @(negedge clk);
         end
         chk("busy_len", SYNC_CLK + END_CLK + WORD_CLK * n, c);
         chk("words", n, s);
         @(negedge clk);
         if (ch < 2)
            chk("next_busy", 1, chan_read_busy[ch+1] === 1'b1);
      end
      chk("owner_high", 1, mem_owner_host === 1'b1);
      chk("access_time", 1, cyc - ln_start <= ACCESS_LIMIT_CLK);
   endtask

   always @(posedge raster_read_start) chk_read();

   initial begin
      repeat (2) @(negedge clk);
      chk("reset_values", 1, comp_blank === 1'b1 && mem_owner_host === 1'b1 && line_gate === 1'b0);
      repeat (3) @(posedge clk);
      #1;
      srst = 1'b0;
      fill = 1'b1;
      @(posedge clk);
      #1;
      fill = 1'b0;
      for (int i = 0; i < 70000 && line_no < 16; i++)
         @(posedge clk);
      chk("lines_reached", 16, line_no);
      chk("param_reads", 5, n_rd);
      print_verdict();
   end
endmodule
